// [pkg/regbank_pkg.sv]
// Purpose: constants and types for the regulator setting register bank
// Assumes: 8-bit register port, byte addresses
// Notes: reset values of settings are module parameters (factory options)
package regbank_pkg;

  // ****************************************
  // register offsets
  // ****************************************
  localparam logic [7:0] OFS_IDENTITY = 8'h00;
  localparam logic [7:0] OFS_CONV1 = 8'h01;
  localparam logic [7:0] OFS_CONV2 = 8'h02;
  localparam logic [7:0] OFS_CONV3 = 8'h03;
  localparam logic [7:0] OFS_CONV4 = 8'h04;
  localparam logic [7:0] OFS_RAMP_EN = 8'h05;
  localparam logic [7:0] OFS_MODE = 8'h06;
  localparam logic [7:0] OFS_LIN1 = 8'h07;
  localparam logic [7:0] OFS_LIN2 = 8'h08;
  localparam logic [7:0] OFS_LIN3 = 8'h09;

  // ****************************************
  // field positions and masks
  // ****************************************
  localparam int LEVEL_LSB = 2;
  localparam int RAMP_EN_LSB = 4;
  localparam int OPSEL_LSB = 4;
  localparam int DISCH_LSB = 0;
  localparam logic [7:0] RAMP_EN_MASK = 8'hF0;
  localparam logic [7:0] LIN_MASK = 8'h7F;

  // ****************************************
  // values after reset (factory defaults)
  // ****************************************
  localparam logic [7:0] CONV_RST_VAL = 8'h00;
  localparam logic [7:0] RAMP_EN_RST_VAL = 8'h00;
  localparam logic [7:0] MODE_RST_VAL = 8'h00;
  localparam logic [7:0] LIN_RST_VAL = 8'h00;
  localparam logic [7:0] RDATA_RST_VAL = 8'h00;

  // ****************************************
  // saturation points and level steps
  // ****************************************
  localparam logic [5:0] CONV_LO_SAT = 6'h2C;
  localparam logic [5:0] CONV_HI_SAT = 6'h3A;
  localparam logic [6:0] LIN_SAT = 7'h50;
  localparam int CONV_LO_BASE_MV = 700;
  localparam int CONV_LO_STEP_MV = 25;
  localparam int CONV_HI_BASE_MV = 700;
  localparam int CONV_HI_STEP_MV = 50;
  localparam int LIN_BASE_MV = 1600;
  localparam int LIN_STEP_MV = 25;
  localparam int RAMP_LO_BASE_MV = 25;
  localparam int RAMP_HI_BASE_MV = 50;

  // ****************************************
  // converter control carrier
  // ****************************************
  typedef struct packed {
    logic [11:0] targetMv;
    logic [9:0] slewMvPer10us;
    logic rampOn;
    logic autoMode;
    logic offDischarge;
  } conv_ctl_t;

endpackage : regbank_pkg

// [rtl/regulator_setting_register_bank.sv]
// Purpose: register bank holding converter and linear regulator settings
// Assumes: serial-bus front end delivers single-cycle byte writes and reads
// Notes: analog controls are decoded levels in mV and slopes in mV per 10 us
//
// Operation
// - converters 1-2: 0.7V base, 25mV step, 1.8V cap
// - converters 3-4: 0.7V base, 50mV step, 3.6V cap
// - converters 1-2 slope 25/50/100/200 mV
// - converters 3-4 slope 50/100/200/400 mV
// - ramp enable bits 7:4: step or slope
// - mode bits 7:4: forced PWM or auto
// - mode bits 3:0: float or discharge when off
// - linear 1-3: 1.6V base, 25mV step, 3.6V cap
`timescale 1ns/1ps
module regulator_setting_register_bank
  import regbank_pkg::*;
#(
  parameter logic [3:0] MAKER_CODE = 4'h5, // arbitrary value
  parameter logic [3:0] SILICON_REVISION = 4'h1, // arbitrary value
  parameter logic [7:0] CONV_RESET = CONV_RST_VAL,
  parameter logic [7:0] RAMP_EN_RESET = RAMP_EN_RST_VAL,
  parameter logic [7:0] MODE_RESET = MODE_RST_VAL,
  parameter logic [7:0] LIN_RESET = LIN_RST_VAL
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWdata,
  output logic [7:0] regRdata,
  output logic regRvalid,
  output conv_ctl_t convCtl [4],
  output logic [11:0] linregTargetMv [3]
);

  if ((RAMP_EN_RESET & ~RAMP_EN_MASK) != 8'h00 ||
      (LIN_RESET & ~LIN_MASK) != 8'h00) begin : gBadReset
    $error("reserved bits set in reset value");
  end

  // ****************************************
  // storage
  // ****************************************
  logic [7:0] convReg [4];
  logic [7:0] convNext [4];
  logic [7:0] rampEnReg, rampEnNext;
  logic [7:0] modeReg, modeNext;
  logic [7:0] linReg [3];
  logic [7:0] linNext [3];
  logic [7:0] rdataReg, rdataNext;
  logic rvalidReg, rvalidNext;

  always_comb begin
    for (int i = 0; i < 4; i++) begin
      convNext[i] = convReg[i];
      if (regWrite && regAddr == OFS_CONV1 + 8'(i)) begin
        convNext[i] = regWdata;
      end
    end
    for (int i = 0; i < 3; i++) begin
      linNext[i] = linReg[i];
      if (regWrite && regAddr == OFS_LIN1 + 8'(i)) begin
        linNext[i] = regWdata & LIN_MASK;
      end
    end
    rampEnNext = rampEnReg;
    if (regWrite && regAddr == OFS_RAMP_EN) begin
      rampEnNext = regWdata & RAMP_EN_MASK;
    end
    modeNext = modeReg;
    if (regWrite && regAddr == OFS_MODE) begin
      modeNext = regWdata;
    end
    rvalidNext = regRead;
    rdataNext = rdataReg;
    if (regRead) begin
      case (regAddr)
        OFS_IDENTITY: rdataNext = {MAKER_CODE, SILICON_REVISION};
        OFS_CONV1: rdataNext = convReg[0];
        OFS_CONV2: rdataNext = convReg[1];
        OFS_CONV3: rdataNext = convReg[2];
        OFS_CONV4: rdataNext = convReg[3];
        OFS_RAMP_EN: rdataNext = rampEnReg;
        OFS_MODE: rdataNext = modeReg;
        OFS_LIN1: rdataNext = linReg[0];
        OFS_LIN2: rdataNext = linReg[1];
        OFS_LIN3: rdataNext = linReg[2];
        default: rdataNext = 8'h00;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      for (int i = 0; i < 4; i++) begin
        convReg[i] <= CONV_RESET;
      end
      for (int i = 0; i < 3; i++) begin
        linReg[i] <= LIN_RESET;
      end
      rampEnReg <= RAMP_EN_RESET;
      modeReg <= MODE_RESET;
      rdataReg <= RDATA_RST_VAL;
      rvalidReg <= 1'b0;
    end else begin
      convReg <= convNext;
      linReg <= linNext;
      rampEnReg <= rampEnNext;
      modeReg <= modeNext;
      rdataReg <= rdataNext;
      rvalidReg <= rvalidNext;
    end
  end

  assign regRdata = rdataReg;
  assign regRvalid = rvalidReg;

  // ****************************************
  // analog control decode
  // ****************************************
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : gConv
      logic [5:0] code;
      logic [5:0] sat;
      logic [1:0] rate;
      assign code = convReg[g][7:LEVEL_LSB];
      assign rate = convReg[g][1:0];
      if (g < 2) begin : gLo
        assign sat = (code >= CONV_LO_SAT) ? CONV_LO_SAT : code;
        assign convCtl[g].targetMv = 12'(CONV_LO_BASE_MV + CONV_LO_STEP_MV * sat);
        assign convCtl[g].slewMvPer10us = 10'(RAMP_LO_BASE_MV << rate);
      end else begin : gHi
        assign sat = (code >= CONV_HI_SAT) ? CONV_HI_SAT : code;
        assign convCtl[g].targetMv = 12'(CONV_HI_BASE_MV + CONV_HI_STEP_MV * sat);
        assign convCtl[g].slewMvPer10us = 10'(RAMP_HI_BASE_MV << rate);
      end
      // converter 1 maps to bit 7, converter 4 to bit 4; for discharge converter 1 maps to bit 3, converter 4 to bit 0
      assign convCtl[g].rampOn = rampEnReg[RAMP_EN_LSB + 3 - g];
      assign convCtl[g].autoMode = modeReg[OPSEL_LSB + 3 - g];
      assign convCtl[g].offDischarge = modeReg[DISCH_LSB + 3 - g];
    end
    for (g = 0; g < 3; g++) begin : gLin
      logic [6:0] lcode;
      assign lcode = (linReg[g][6:0] >= LIN_SAT) ? LIN_SAT : linReg[g][6:0];
      assign linregTargetMv[g] = 12'(LIN_BASE_MV + LIN_STEP_MV * lcode);
    end
  endgenerate

  // ****************************************
  // checks
  // ****************************************
  sequence wrConv1_s;
    regWrite && regAddr == OFS_CONV1;
  endsequence
  sequence rdConv1_s;
    regRead && regAddr == OFS_CONV1 && !regWrite;
  endsequence
  sequence wrRampEn_s;
    regWrite && regAddr == OFS_RAMP_EN;
  endsequence
  sequence wrMode_s;
    regWrite && regAddr == OFS_MODE;
  endsequence

  // write, one quiet cycle, then read back
  readback_conv_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    wrConv1_s ##1 !regWrite ##1 rdConv1_s |=> regRdata == $past(regWdata, 3))
    else $error("converter readback mismatch");
  rvalid_pulse_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    regRead |=> regRvalid)
    else $error("read answer missing");
  rvalid_idle_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    !regRead |=> !regRvalid)
    else $error("read answer without request");
  identity_ro_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    regRead && regAddr == OFS_IDENTITY |=> regRdata == {MAKER_CODE, SILICON_REVISION})
    else $error("identity changed");
  unmapped_zero_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    regRead && regAddr > OFS_LIN3 |=> regRdata == 8'h00)
    else $error("unmapped read not zero");
  reserved_zero_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    rampEnReg[3:0] == 4'h0 && linReg[0][7] == 1'b0)
    else $error("reserved bit set");
  conv1_sat_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    convReg[0][7:2] >= 6'h2C |-> convCtl[0].targetMv == 12'h708)
    else $error("converter 1 not capped");
  conv2_base_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    convReg[1][7:2] == 6'h00 |-> convCtl[1].targetMv == 12'h2BC)
    else $error("converter 2 base level wrong");
  conv3_sat_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    convReg[2][7:2] >= 6'h3A |-> convCtl[2].targetMv == 12'hE10)
    else $error("converter 3 not capped");
  conv4_step_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    convReg[3][7:2] == 6'h01 |-> convCtl[3].targetMv == 12'h2EE)
    else $error("converter 4 step wrong");
  conv1_slew_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    convReg[0][1:0] == 2'h3 |-> convCtl[0].slewMvPer10us == 10'h0C8)
    else $error("converter 1 slope wrong");
  conv4_slew_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    convReg[3][1:0] == 2'h0 |-> convCtl[3].slewMvPer10us == 10'h032)
    else $error("converter 4 slope wrong");
  ramp_map_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    wrRampEn_s |=> convCtl[0].rampOn == $past(regWdata[7]))
    else $error("ramp enable mapping wrong");
  ramp_hold_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    !(regWrite && regAddr == OFS_RAMP_EN) |=> $stable(rampEnReg))
    else $error("ramp enable changed without write");
  mode_map_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    wrMode_s |=> convCtl[3].autoMode == $past(regWdata[4]))
    else $error("mode mapping wrong");
  mode_hold_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    !(regWrite && regAddr == OFS_MODE) |=> $stable(modeReg))
    else $error("mode changed without write");
  disch_map_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    wrMode_s |=> convCtl[0].offDischarge == $past(regWdata[3]))
    else $error("discharge mapping wrong");
  lin_sat_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    linReg[1][6:0] >= 7'h50 |-> linregTargetMv[1] == 12'hE10)
    else $error("linear regulator not capped");
  lin_base_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    linReg[2][6:0] == 7'h00 |-> linregTargetMv[2] == 12'h640)
    else $error("linear regulator base level wrong");

endmodule : regulator_setting_register_bank

// [bench/reg_host.sv]
// Purpose: host model driving single-byte register strobes
// Assumes: strobes change at the falling edge of ref_clk
// Notes: released address and data lines show inverted last values
`timescale 1ns/1ps
module reg_host (
  input wire logic ref_clk,
  output logic regWrite,
  output logic regRead,
  output logic [7:0] regAddr,
  output logic [7:0] regWdata,
  input wire logic [7:0] regRdata,
  input wire logic regRvalid
);
  initial begin
    regWrite = 1'b0;
    regRead = 1'b0;
    regAddr = 8'h00;
    regWdata = 8'h00;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    regWrite = 1'b1;
    regAddr = a;
    regWdata = d;
    @(negedge ref_clk);
    regWrite = 1'b0;
    regAddr = ~a;
    regWdata = ~d;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
    @(negedge ref_clk);
    regRead = 1'b1;
    regAddr = a;
    @(negedge ref_clk);
    regRead = 1'b0;
    regAddr = ~a;
    v = regRvalid;
    d = regRdata;
  endtask : rd
endmodule : reg_host

// [bench/tb_top.sv]
// Purpose: self-checking bench for the regulator setting register bank
// Assumes: one-cycle strobes, read answer one cycle later
// Notes: identity parameters set to arbitrary values
`timescale 1ns/1ps
`define CHK(a, b) begin checksDone++; if ((a) !== (b)) begin errors++; \
  $display("[ERR] %0t got %h exp %h", $time, a, b); end end
module tb_top
  import regbank_pkg::*;
;
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic regWrite, regRead, regRvalid;
  logic [7:0] regAddr, regWdata, regRdata;
  conv_ctl_t convCtl [4];
  logic [11:0] linregTargetMv [3];
  int errors = 0;
  int checksDone = 0;
  int cycles = 0;
  // identity values are arbitrary
  regulator_setting_register_bank #(.MAKER_CODE(4'hA), .SILICON_REVISION(4'h3)) dut (
    .ref_clk(ref_clk), .reset_n(reset_n), .regWrite(regWrite), .regRead(regRead),
    .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata), .regRvalid(regRvalid),
    .convCtl(convCtl), .linregTargetMv(linregTargetMv));
  reg_host host (.ref_clk(ref_clk), .regWrite(regWrite), .regRead(regRead),
    .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata), .regRvalid(regRvalid));
  initial begin
    forever #25 ref_clk = ~ref_clk;
  end
  task automatic finalReport();
    if (errors == 0 && checksDone > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : finalReport
  task automatic chkRd(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    logic v;
    host.rd(a, d, v);
    `CHK(v, 1'b1)
    `CHK(d, e)
  endtask : chkRd
  task automatic t_reset();
    host.wr(OFS_IDENTITY, 8'h5A);
    chkRd(OFS_IDENTITY, 8'hA3);
    for (int a = 1; a < 12; a++) chkRd((a < 10) ? 8'(a) : 8'hF0 + 8'(a), 8'h00);
  endtask : t_reset
  task automatic t_conv();
    logic [5:0] codes [8] = '{6'h00, 6'h01, 6'h2B, 6'h2C, 6'h2D, 6'h39, 6'h3A, 6'h3F};
    int c, sat;
    for (int i = 0; i < 8; i++) begin
      for (int k = 0; k < 4; k++) begin
        c = codes[i];
        sat = (k < 2) ? 44 : 58;
        host.wr(8'(k + 1), {codes[i], 2'(i)});
        `CHK(convCtl[k].targetMv, 12'(((k < 2) ? 25 : 50) * ((c < sat) ? c : sat) + 700))
        `CHK(convCtl[k].slewMvPer10us, 10'(((k < 2) ? 25 : 50) << (i % 4)))
        chkRd(8'(k + 1), {codes[i], 2'(i)});
      end
    end
  endtask : t_conv
  task automatic t_flags();
    logic [7:0] m;
    for (int b = 0; b < 4; b++) begin
      m = (8'h80 >> b) | (8'h01 << b);
      host.wr(OFS_RAMP_EN, (8'h80 >> b) | 8'h0F);
      host.wr(OFS_MODE, m);
      for (int j = 0; j < 4; j++) begin
        `CHK(convCtl[j].rampOn, 1'(j == b))
        `CHK(convCtl[j].autoMode, 1'(j == b))
        `CHK(convCtl[j].offDischarge, 1'(j == 3 - b))
      end
      chkRd(OFS_RAMP_EN, 8'h80 >> b);
      chkRd(OFS_MODE, m);
    end
  endtask : t_flags
  task automatic t_lin();
    logic [6:0] codes [5] = '{7'h00, 7'h01, 7'h4F, 7'h50, 7'h7F};
    int c;
    for (int i = 0; i < 5; i++) begin
      for (int k = 0; k < 3; k++) begin
        c = codes[i];
        host.wr(OFS_LIN1 + 8'(k), {1'b1, codes[i]});
        `CHK(linregTargetMv[k], 12'(25 * ((c < 80) ? c : 80) + 1600))
        chkRd(OFS_LIN1 + 8'(k), {1'b0, codes[i]});
      end
    end
  endtask : t_lin
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 5000) begin
      errors++;
      finalReport();
    end
  end
  initial begin
    repeat (12) @(posedge ref_clk);
    @(negedge ref_clk);
    reset_n = 1'b1;
    t_reset();
    t_conv();
    t_flags();
    t_lin();
    finalReport();
  end
endmodule : tb_top
